/* rtl/bsync_pkg.sv */
package bsync_pkg;
  localparam int DW = 16;
  localparam int NSTAGE = 3;
  localparam int NCHAN = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MAGLIM = 8'h04;
  localparam logic [7:0] ADDR_FRQLIM = 8'h08;
  localparam logic [7:0] ADDR_ANGLIM = 8'h0c;
  localparam logic [7:0] ADDR_LIVE   = 8'h10;
  localparam logic [7:0] ADDR_DEAD   = 8'h14;
  localparam logic [7:0] ADDR_VCOND  = 8'h18;
  localparam logic [7:0] ADDR_STAT   = 8'h1c;
  localparam logic [7:0] ADDR_IRQST  = 8'h20;
  localparam logic [7:0] ADDR_IRQMSK = 8'h24;
  localparam int CTL_SS3 = 0;
  localparam int CTL_SS4 = 1;
  localparam int CTL_SWEN = 2;
  localparam int CTL_INDIV = 3;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_REF1_LSB = 8;
  localparam int CTL_REF2_LSB = 12;
  localparam int VC_W = 4;
  localparam int IRQ_SYNC_LSB = 0;
  localparam int IRQ_CLOSE = 3;
  localparam int IRQ_BLOCK = 4;
  localparam int IRQ_W = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] MAGLIM_RST = 16'h01f4;
  localparam logic [15:0] FRQLIM_RST = 16'h0064;
  localparam logic [15:0] ANGLIM_RST = 16'h03e8;
  localparam logic [15:0] LIVE_RST = 16'h1f40;
  localparam logic [15:0] DEAD_RST = 16'h07d0;
  localparam logic [11:0] VCOND_RST = 12'h111;
  localparam int ANG_FULL = 36000;
  localparam int ANG_HALF = 18000;
  localparam logic [2:0] CH_UL1 = 3'h0;
  localparam logic [2:0] CH_UL12 = 3'h3;
  localparam logic [2:0] CH_UL31 = 3'h5;
  localparam logic [2:0] CH_U3 = 3'h6;
  localparam logic [2:0] CH_U4 = 3'h7;
  localparam int REFRESH_MS = 5;
  localparam int CLK_KHZ = 50000;
  localparam int REFRESH_CYC = REFRESH_MS * CLK_KHZ;
  typedef enum logic [2:0] {
    BSY_ON      = 3'h0,
    BSY_BLOCKED = 3'h1,
    BSY_TEST    = 3'h2,
    BSY_TESTBLK = 3'h3,
    BSY_OFF     = 3'h4
  } bsync_beh_t;
  typedef enum logic [2:0] {
    CL_IDLE  = 3'b001,
    CL_PULSE = 3'b010,
    CL_WAIT  = 3'b100
  } bsync_cl_t;
endpackage

/* rtl/bsync_cmp_if.sv */
`timescale 1ns/1ns
interface bsync_cmp_if #(
  parameter int W = 16
);
  logic         en;
  logic         supp;
  logic [W-1:0] magA, magB, frqA, frqB, angA, angB;
  logic [W-1:0] magLim, frqLim, angLim, liveLvl, deadLvl;
  logic [3:0]   vcond;
  logic         magOk, frqOk, angOk, liveA, deadA, liveB, deadB;
  logic         synced;
  modport stage (
    input  en, supp, magA, magB, frqA, frqB, angA, angB,
    input  magLim, frqLim, angLim, liveLvl, deadLvl, vcond,
    output magOk, frqOk, angOk, liveA, deadA, liveB, deadB, synced
  );
  modport ctrl (
    output en, supp, magA, magB, frqA, frqB, angA, angB,
    output magLim, frqLim, angLim, liveLvl, deadLvl, vcond,
    input  magOk, frqOk, angOk, liveA, deadA, liveB, deadB, synced
  );
endinterface

/* rtl/bsync_stage.sv */
`timescale 1ns/1ns
module bsync_stage #(
  parameter int W = 16
) (
  input wire logic   clock,
  input wire logic   srst,
  bsync_cmp_if.stage c
);
  localparam logic [W:0] ANG_FULL = (W+1)'(bsync_pkg::ANG_FULL);
  localparam logic [W:0] ANG_HALF = (W+1)'(bsync_pkg::ANG_HALF);

  function automatic logic [W:0] absDiff(input logic [W:0] a,
                                         input logic [W:0] b);
    logic [W:0] d;
    if ($signed(a) >= $signed(b)) begin
      d = a - b;
    end else begin
      d = b - a;
    end
    return d;
  endfunction

  logic [W:0] magD, frqD, angRaw, angD;
  logic [3:0] combo;
  logic       magOkNxt, frqOkNxt, angOkNxt;
  logic       liveANxt, deadANxt, liveBNxt, deadBNxt, syncNxt;

  always_comb begin
    magD = absDiff({1'b0, c.magA}, {1'b0, c.magB});
    frqD = absDiff({c.frqA[W-1], c.frqA}, {c.frqB[W-1], c.frqB});
    angRaw = absDiff({c.angA[W-1], c.angA}, {c.angB[W-1], c.angB});
    angD = (angRaw > ANG_HALF) ? ANG_FULL - angRaw : angRaw;
    // RL7: difference within limit
    magOkNxt = magD <= {1'b0, c.magLim};
    frqOkNxt = frqD <= {1'b0, c.frqLim};
    angOkNxt = angD <= {1'b0, c.angLim};
    // RL8: live and dead classes
    liveANxt = c.magA > c.liveLvl;
    deadANxt = c.magA < c.deadLvl;
    liveBNxt = c.magB > c.liveLvl;
    deadBNxt = c.magB < c.deadLvl;
    // RL9: voltage condition mask
    combo = {deadANxt & deadBNxt, deadANxt & liveBNxt,
             liveANxt & deadBNxt, liveANxt & liveBNxt};
    // RL6: all three aspects match
    syncNxt = c.en & ~c.supp & magOkNxt & frqOkNxt & angOkNxt
              & (|(combo & c.vcond));
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      c.magOk <= 1'b0;
      c.frqOk <= 1'b0;
      c.angOk <= 1'b0;
      c.liveA <= 1'b0;
      c.deadA <= 1'b0;
      c.liveB <= 1'b0;
      c.deadB <= 1'b0;
      c.synced <= 1'b0;
    end else begin
      c.magOk <= magOkNxt;
      c.frqOk <= frqOkNxt;
      c.angOk <= angOkNxt;
      c.liveA <= liveANxt;
      c.deadA <= deadANxt;
      c.liveB <= liveBNxt;
      c.deadB <= deadBNxt;
      c.synced <= syncNxt;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_all_match;
    c.synced |-> c.magOk && c.frqOk && c.angOk;
  endproperty
  a_all_match: assert property (p_all_match) // RL6
    else $error("synced without all three matches");

  property p_mag_limit;
    !$past(srst) |-> c.magOk == ($past(magD) <= {1'b0, $past(c.magLim)});
  endproperty
  a_mag_limit: assert property (p_mag_limit) // RL7
    else $error("magnitude match wrong");

  property p_vcond;
    c.synced |-> |(c.vcond & {c.deadA & c.deadB, c.deadA & c.liveB,
                              c.liveA & c.deadB, c.liveA & c.liveB})
                 || $changed(c.vcond);
  endproperty
  a_vcond: assert property (p_vcond) // RL9
    else $error("synced with disallowed voltage state");

  property p_suppress;
    $past(c.supp) |-> !c.synced;
  endproperty
  a_suppress: assert property (p_suppress) // RL15
    else $error("synced while suppressed");
endmodule

/* rtl/bsync_top.sv */
`timescale 1ns/1ns
// Function
// RL1: Single source channel is compared with any selectable system voltage.
// RL2: With a single source channel, stages two and three stay inactive.
// RL3: With both sources, stage one compares channel three to phase pair.
// RL4: With both sources, stage two compares channel four to phase pair.
// RL5: With both sources, stage three compares channel three to four.
// RL6: Synchronized only when magnitude, frequency and angle all match.
// RL7: A comparison matches when difference does not exceed its limit.
// RL8: Side is live above live level, dead below dead level.
// RL9: Per-stage voltage condition selects required live/dead combinations.
// RL10: Synchroswitching closes the breaker once sides are synchronized.
// RL11: For three breakers, software gives stages one and two same reference.
// RL12: Channel measurements refresh on a five millisecond time base.
// RL13: Frequency, angle and magnitude are tracked for each channel.
// RL14: Behaviour indication readable, shown only when individual mode allowed.
// RL15: Synchronized and close are suppressed while blocked or off.
module bsync_top #(
  parameter int W           = bsync_pkg::DW,
  parameter int REFRESH_CYC = bsync_pkg::REFRESH_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdata,
  input  wire logic                 blockIn,
  input  wire logic [7:0][W-1:0]    chanMag,
  input  wire logic [7:0][W-1:0]    chanFrq,
  input  wire logic [7:0][W-1:0]    chanAng,
  output logic                      breakerClose,
  output logic      [2:0]           syncedOut,
  output logic                      irq
);
  localparam int CW = $clog2(REFRESH_CYC + 1);
  localparam int NS = bsync_pkg::NSTAGE;

  function automatic logic [2:0] refAny(input logic [2:0] sel);
    return (sel <= bsync_pkg::CH_UL31) ? sel : bsync_pkg::CH_UL1;
  endfunction

  function automatic logic [2:0] refPair(input logic [2:0] sel);
    return (sel >= bsync_pkg::CH_UL12 && sel <= bsync_pkg::CH_UL31)
           ? sel : bsync_pkg::CH_UL12;
  endfunction

  logic [31:0]                  ctrl_r;
  logic [W-1:0]                 magLim_r, frqLim_r, angLim_r;
  logic [W-1:0]                 live_r, dead_r;
  logic [11:0]                  vcond_r;
  logic [bsync_pkg::IRQ_W-1:0]  irqSt_r, irqMsk_r, irqEv;
  logic [31:0]                  regRdata_r;
  logic [CW-1:0]                tickCnt_r;
  logic                         tick_r;
  logic [7:0][W-1:0]            mag_r, frq_r, ang_r;
  logic                         blkMeta_r, blkSync_r, blkPrev_r;
  bsync_pkg::bsync_beh_t        beh_r, behNxt;
  bsync_pkg::bsync_cl_t         clState_r;
  logic                         breakerClose_r, irq_r;
  logic [2:0]                   syncPrev_r;
  logic [NS-1:0]                stgEn, synced, magOk, frqOk, angOk;
  logic [NS-1:0][2:0]           selA, selB;
  logic                         ss3, ss4, oneSrc, bothSrc, swEn;
  logic                         suppress, anySync, wrIrqSt;

  assign ss3 = ctrl_r[bsync_pkg::CTL_SS3];
  assign ss4 = ctrl_r[bsync_pkg::CTL_SS4];
  assign swEn = ctrl_r[bsync_pkg::CTL_SWEN];
  assign oneSrc = ss3 ^ ss4;
  assign bothSrc = ss3 & ss4;
  assign wrIrqSt = regWr && regAddr == bsync_pkg::ADDR_IRQST;

  // Register writes
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_r <= bsync_pkg::CTRL_RST;
      magLim_r <= W'(bsync_pkg::MAGLIM_RST);
      frqLim_r <= W'(bsync_pkg::FRQLIM_RST);
      angLim_r <= W'(bsync_pkg::ANGLIM_RST);
      live_r <= W'(bsync_pkg::LIVE_RST);
      dead_r <= W'(bsync_pkg::DEAD_RST);
      vcond_r <= bsync_pkg::VCOND_RST;
      irqMsk_r <= '0;
    end else if (regWr) begin
      case (regAddr)
        bsync_pkg::ADDR_CTRL: begin
          ctrl_r <= {16'h0000, regWdata[15:0]};
        end
        bsync_pkg::ADDR_MAGLIM: magLim_r <= regWdata[W-1:0];
        bsync_pkg::ADDR_FRQLIM: frqLim_r <= regWdata[W-1:0];
        bsync_pkg::ADDR_ANGLIM: angLim_r <= regWdata[W-1:0];
        bsync_pkg::ADDR_LIVE: live_r <= regWdata[W-1:0];
        bsync_pkg::ADDR_DEAD: dead_r <= regWdata[W-1:0];
        bsync_pkg::ADDR_VCOND: vcond_r <= regWdata[11:0];
        bsync_pkg::ADDR_IRQMSK: begin
          irqMsk_r <= regWdata[bsync_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge clock) begin
    if (srst || !regRd) begin
      regRdata_r <= 32'h0000_0000;
    end else begin
      case (regAddr)
        bsync_pkg::ADDR_CTRL: regRdata_r <= ctrl_r;
        bsync_pkg::ADDR_MAGLIM: regRdata_r <= 32'(magLim_r);
        bsync_pkg::ADDR_FRQLIM: regRdata_r <= 32'(frqLim_r);
        bsync_pkg::ADDR_ANGLIM: regRdata_r <= 32'(angLim_r);
        bsync_pkg::ADDR_LIVE: regRdata_r <= 32'(live_r);
        bsync_pkg::ADDR_DEAD: regRdata_r <= 32'(dead_r);
        bsync_pkg::ADDR_VCOND: regRdata_r <= {20'h00000, vcond_r};
        // RL14: indication hidden unless allowed
        bsync_pkg::ADDR_STAT: begin
          regRdata_r <= {7'h00, angOk & stgEn, frqOk & stgEn, magOk & stgEn,
                         4'h0, ctrl_r[bsync_pkg::CTL_INDIV],
                         ctrl_r[bsync_pkg::CTL_INDIV] ? beh_r : 3'h0,
                         1'b0, synced, 1'b0, stgEn};
        end
        bsync_pkg::ADDR_IRQST: regRdata_r <= 32'(irqSt_r);
        bsync_pkg::ADDR_IRQMSK: regRdata_r <= 32'(irqMsk_r);
        default: regRdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // RL12: five millisecond refresh tick
  always_ff @(posedge clock) begin
    if (srst) begin
      tickCnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tickCnt_r == CW'(REFRESH_CYC - 1)) begin
      tickCnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // RL13: track magnitude, frequency, angle
  always_ff @(posedge clock) begin
    if (srst) begin
      mag_r <= '0;
      frq_r <= '0;
      ang_r <= '0;
    end else if (tick_r) begin
      mag_r <= chanMag;
      frq_r <= chanFrq;
      ang_r <= chanAng;
    end
  end

  // Block pin synchroniser
  always_ff @(posedge clock) begin
    if (srst) begin
      blkMeta_r <= 1'b0;
      blkSync_r <= 1'b0;
      blkPrev_r <= 1'b0;
    end else begin
      blkMeta_r <= blockIn;
      blkSync_r <= blkMeta_r;
      blkPrev_r <= blkSync_r;
    end
  end

  // RL14: effective behaviour
  always_comb begin
    case (ctrl_r[bsync_pkg::CTL_MODE_LSB +: 3])
      3'h0: behNxt = blkSync_r ? bsync_pkg::BSY_BLOCKED : bsync_pkg::BSY_ON;
      3'h1: behNxt = bsync_pkg::BSY_BLOCKED;
      3'h2: behNxt = blkSync_r ? bsync_pkg::BSY_TESTBLK : bsync_pkg::BSY_TEST;
      3'h3: behNxt = bsync_pkg::BSY_TESTBLK;
      default: behNxt = bsync_pkg::BSY_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      beh_r <= bsync_pkg::BSY_ON;
    end else begin
      beh_r <= behNxt;
    end
  end

  // RL15: block and off suppress
  assign suppress = beh_r == bsync_pkg::BSY_BLOCKED
                 || beh_r == bsync_pkg::BSY_TESTBLK
                 || beh_r == bsync_pkg::BSY_OFF;

  // Stage routing
  always_comb begin
    stgEn = '0;
    selA = '0;
    selB = '0;
    // RL1: single source stage one
    if (oneSrc) begin
      // RL2: later stages off
      stgEn = 3'b001;
      selA[0] = ss3 ? bsync_pkg::CH_U3 : bsync_pkg::CH_U4;
      selB[0] = refAny(ctrl_r[bsync_pkg::CTL_REF1_LSB +: 3]);
    end
    if (bothSrc) begin
      stgEn = 3'b111;
      // RL3: channel three versus pair
      selA[0] = bsync_pkg::CH_U3;
      selB[0] = refPair(ctrl_r[bsync_pkg::CTL_REF1_LSB +: 3]);
      // RL4: channel four versus pair
      selA[1] = bsync_pkg::CH_U4;
      selB[1] = refPair(ctrl_r[bsync_pkg::CTL_REF2_LSB +: 3]);
      // RL5: channel three versus four
      selA[2] = bsync_pkg::CH_U3;
      selB[2] = bsync_pkg::CH_U4;
    end
  end

  for (genvar i = 0; i < NS; i++) begin : g_stage
    bsync_cmp_if #(.W(W)) cmp ();
    assign cmp.en = stgEn[i];
    assign cmp.supp = suppress;
    assign cmp.magA = mag_r[selA[i]];
    assign cmp.magB = mag_r[selB[i]];
    assign cmp.frqA = frq_r[selA[i]];
    assign cmp.frqB = frq_r[selB[i]];
    assign cmp.angA = ang_r[selA[i]];
    assign cmp.angB = ang_r[selB[i]];
    assign cmp.magLim = magLim_r;
    assign cmp.frqLim = frqLim_r;
    assign cmp.angLim = angLim_r;
    assign cmp.liveLvl = live_r;
    assign cmp.deadLvl = dead_r;
    assign cmp.vcond = vcond_r[i*bsync_pkg::VC_W +: bsync_pkg::VC_W];
    assign synced[i] = cmp.synced;
    assign magOk[i] = cmp.magOk;
    assign frqOk[i] = cmp.frqOk;
    assign angOk[i] = cmp.angOk;
    bsync_stage #(.W(W)) u_stage (
      .clock (clock),
      .srst  (srst),
      .c     (cmp)
    );
  end

  assign anySync = |(synced & stgEn);

  // RL10: synchroswitching close sequence
  always_ff @(posedge clock) begin
    if (srst) begin
      clState_r <= bsync_pkg::CL_IDLE;
      breakerClose_r <= 1'b0;
    end else begin
      breakerClose_r <= 1'b0;
      case (clState_r)
        bsync_pkg::CL_IDLE: begin
          if (swEn && anySync && !suppress) begin
            clState_r <= bsync_pkg::CL_PULSE;
            breakerClose_r <= 1'b1;
          end
        end
        bsync_pkg::CL_PULSE: clState_r <= bsync_pkg::CL_WAIT;
        bsync_pkg::CL_WAIT: begin
          if (!anySync) begin
            clState_r <= bsync_pkg::CL_IDLE;
          end
        end
        default: clState_r <= bsync_pkg::CL_IDLE;
      endcase
    end
  end

  // Sticky events, set wins over clear
  assign irqEv = {blkSync_r & ~blkPrev_r, breakerClose_r,
                  synced & ~syncPrev_r};

  always_ff @(posedge clock) begin
    if (srst) begin
      irqSt_r <= '0;
      syncPrev_r <= '0;
      irq_r <= 1'b0;
    end else begin
      syncPrev_r <= synced;
      irqSt_r <= (irqSt_r & ~(wrIrqSt ? regWdata[bsync_pkg::IRQ_W-1:0]
                                      : '0)) | irqEv;
      irq_r <= |(irqSt_r & irqMsk_r);
    end
  end

  assign regRdata = regRdata_r;
  assign breakerClose = breakerClose_r;
  assign syncedOut = syncPrev_r;
  assign irq = irq_r;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_single_src;
    oneSrc |-> stgEn == 3'b001
           && selA[0] == (ss3 ? bsync_pkg::CH_U3 : bsync_pkg::CH_U4);
  endproperty
  a_single_src: assert property (p_single_src) // RL1
    else $error("single source routing wrong");

  property p_hidden_stages;
    oneSrc ##1 oneSrc |-> !synced[1] && !synced[2];
  endproperty
  a_hidden_stages: assert property (p_hidden_stages) // RL2
    else $error("inactive stage reports synced");

  property p_stage1_pair;
    bothSrc |-> selA[0] == bsync_pkg::CH_U3 && selB[0] >= bsync_pkg::CH_UL12
             && selB[0] <= bsync_pkg::CH_UL31;
  endproperty
  a_stage1_pair: assert property (p_stage1_pair) // RL3
    else $error("stage one routing wrong");

  property p_stage2_pair;
    bothSrc |-> selA[1] == bsync_pkg::CH_U4 && selB[1] >= bsync_pkg::CH_UL12
             && selB[1] <= bsync_pkg::CH_UL31;
  endproperty
  a_stage2_pair: assert property (p_stage2_pair) // RL4
    else $error("stage two routing wrong");

  property p_stage3_direct;
    bothSrc |-> selA[2] == bsync_pkg::CH_U3 && selB[2] == bsync_pkg::CH_U4;
  endproperty
  a_stage3_direct: assert property (p_stage3_direct) // RL5
    else $error("stage three routing wrong");

  property p_close_cause;
    $rose(breakerClose) |-> $past(swEn && anySync && !suppress)
                            ##1 (!breakerClose)[*2];
  endproperty
  a_close_cause: assert property (p_close_cause) // RL10
    else $error("close without synchronized sides");

  property p_tick_spacing;
    tick_r |=> (!tick_r)[*2];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) // RL12
    else $error("refresh tick too close");

  property p_indication_hidden;
    regRd && regAddr == bsync_pkg::ADDR_STAT
      && !ctrl_r[bsync_pkg::CTL_INDIV] |=> regRdata[11:8] == 4'h0;
  endproperty
  a_indication_hidden: assert property (p_indication_hidden) // RL14
    else $error("behaviour shown while hidden");

  property p_no_close_suppressed;
    suppress |=> !breakerClose;
  endproperty
  a_no_close_suppressed: assert property (p_no_close_suppressed) // RL15
    else $error("close while blocked or off");
endmodule

/* test/bsync_meas_model.sv */
`timescale 1ns/1ns
module bsync_meas_model #(
  parameter int W = 16
) (
  input  wire logic              clock,
  input  wire logic              breakerClose,
  output logic      [7:0][W-1:0] chanMag,
  output logic      [7:0][W-1:0] chanFrq,
  output logic      [7:0][W-1:0] chanAng
);
  int closeCnt = 0;

  // All channels live, in step
  initial begin
    for (int i = 0; i < 8; i++) begin
      chanMag[i] = 16'h2710;
      chanFrq[i] = 16'h1388;
      chanAng[i] = 16'h0000;
    end
  end

  // Close pulses seen at the breaker
  always @(posedge clock) begin
    if (breakerClose) begin
      closeCnt <= closeCnt + 1;
    end
  end

  task automatic setCh(input int i, input int m, input int f, input int a);
    @(posedge clock);
    chanMag[i] <= W'(m);
    chanFrq[i] <= W'(f);
    chanAng[i] <= W'(a);
  endtask
endmodule

/* test/test_breaker_synchrocheck.sv */
`timescale 1ns/1ns
module test_breaker_synchrocheck;
  localparam int RC = 16;
  localparam int W  = bsync_pkg::DW;
  logic              clock, srst, regWr, regRd, blockIn;
  logic              breakerClose, irq;
  logic [7:0]        regAddr;
  logic [31:0]       regWdata, regRdata, d;
  logic [2:0]        syncedOut;
  logic [7:0][W-1:0] chanMag, chanFrq, chanAng;
  int                errorCnt, checksDone, cycles, c0;

  bsync_top #(.REFRESH_CYC(RC)) dut (
    .clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .blockIn(blockIn), .chanMag(chanMag), .chanFrq(chanFrq),
    .chanAng(chanAng), .breakerClose(breakerClose),
    .syncedOut(syncedOut), .irq(irq)
  );

  bsync_meas_model #(.W(W)) meas (
    .clock(clock), .breakerClose(breakerClose), .chanMag(chanMag),
    .chanFrq(chanFrq), .chanAng(chanAng)
  );

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  initial begin
    errorCnt = 0;
    checksDone = 0;
    cycles = 0;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errorCnt++;
      wrapUp();
    end
  end

  task automatic wrapUp();
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrRg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'h1;
    @(posedge clock);
    regWr    <= 1'h0;
  endtask

  task automatic rdRg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge clock);
    regRd   <= 1'h0;
    #1 v = regRdata;
  endtask

  task automatic settle();
    repeat (2 * RC + 4) @(posedge clock);
    #1;
  endtask

  function automatic logic [31:0] ctl(input int s, input int sw,
                                      input int ind, input int md);
    // Both stage references on the phase pair
    return 32'(s) | 32'(sw) << bsync_pkg::CTL_SWEN
         | 32'(ind) << bsync_pkg::CTL_INDIV
         | 32'(md) << bsync_pkg::CTL_MODE_LSB
         | 32'h3 << bsync_pkg::CTL_REF1_LSB
         | 32'h3 << bsync_pkg::CTL_REF2_LSB;
  endfunction

  task automatic tResetVals();
    logic [7:0]  a[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                          8'h18, 8'h28};
    logic [31:0] e[8] = '{32'h0, 32'h1f4, 32'h64, 32'h3e8, 32'h1f40,
                          32'h7d0, 32'h111, 32'h0};
    wrRg(8'h28, 32'hffff);
    for (int i = 0; i < 8; i++) begin
      rdRg(a[i], d);
      chk(d, e[i]);
    end
  endtask

  task automatic tSingle();
    meas.setCh(0, 16'h2ee0, 16'h1388, 0);
    for (int s = 1; s < 3; s++) begin
      wrRg(bsync_pkg::ADDR_CTRL, ctl(s, 0, 0, 0));
      settle();
      chk(32'(syncedOut), 32'h1);
      rdRg(bsync_pkg::ADDR_STAT, d);
      chk(32'(d[2:0]), 32'h1);
      chk(32'(d[18:16]), 32'h1);
      wrRg(bsync_pkg::ADDR_CTRL, ctl(s, 0, 0, 0) & 32'hfffff0ff);
      settle();
      chk(32'(syncedOut), 32'h0);
    end
  endtask

  task automatic tLimits();
    int lim[3] = '{500, 100, 1000};
    int v;
    wrRg(bsync_pkg::ADDR_CTRL, ctl(1, 0, 0, 0));
    for (int q = 0; q < 3; q++) begin
      for (int k = 0; k < 2; k++) begin
        v = lim[q] + k;
        meas.setCh(6, 10000 + (q == 0 ? v : 0),
                   5000 + (q == 1 ? v : 0), q == 2 ? v : 0);
        settle();
        chk(32'(syncedOut), 32'(k == 0));
      end
    end
    meas.setCh(6, 10000, 5000, 0);
  endtask

  task automatic tDual();
    // same reference on stages one and two
    wrRg(bsync_pkg::ADDR_CTRL, ctl(3, 0, 0, 0));
    meas.setCh(7, 10600, 5000, 0);
    settle();
    chk(32'(syncedOut), 32'h1);
    rdRg(bsync_pkg::ADDR_STAT, d);
    chk(32'(d[2:0]), 32'h7);
    meas.setCh(7, 10000, 5000, 0);
    meas.setCh(6, 10600, 5000, 0);
    settle();
    chk(32'(syncedOut), 32'h2);
    meas.setCh(6, 10000, 5000, 0);
    settle();
    chk(32'(syncedOut), 32'h7);
  endtask

  task automatic tVcond();
    int m6[5] = '{0, 0, 10000, 10000, 5000};
    logic [31:0] vc[5] = '{32'h111, 32'h118, 32'h118, 32'h112, 32'h11f};
    int ex[5] = '{0, 1, 0, 1, 0};
    wrRg(bsync_pkg::ADDR_CTRL, ctl(1, 0, 0, 0));
    wrRg(bsync_pkg::ADDR_MAGLIM, 32'hffff);
    meas.setCh(3, 0, 5000, 0);
    for (int i = 0; i < 5; i++) begin
      meas.setCh(6, m6[i], 5000, 0);
      wrRg(bsync_pkg::ADDR_VCOND, vc[i]);
      settle();
      chk(32'(syncedOut), 32'(ex[i]));
    end
    wrRg(bsync_pkg::ADDR_MAGLIM, 32'h1f4);
    wrRg(bsync_pkg::ADDR_VCOND, 32'h111);
    meas.setCh(3, 10000, 5000, 0);
    meas.setCh(6, 10000, 5000, 0);
  endtask

  task automatic tClose();
    chk(32'(meas.closeCnt), 32'h0);
    meas.setCh(6, 12000, 5000, 0);
    wrRg(bsync_pkg::ADDR_CTRL, ctl(1, 1, 0, 0));
    settle();
    wrRg(bsync_pkg::ADDR_IRQST, 32'h1f);
    wrRg(bsync_pkg::ADDR_IRQMSK, 32'h8);
    c0 = meas.closeCnt;
    meas.setCh(6, 10000, 5000, 0);
    settle();
    chk(32'(meas.closeCnt - c0), 32'h1);
    chk(32'(irq), 32'h1);
    rdRg(bsync_pkg::ADDR_IRQST, d);
    chk(32'(d[3]), 32'h1);
    wrRg(bsync_pkg::ADDR_IRQST, 32'h8);
    repeat (3) @(posedge clock);
    #1;
    chk(32'(irq), 32'h0);
  endtask

  task automatic tModes();
    for (int m = 0; m < 5; m++) begin
      wrRg(bsync_pkg::ADDR_CTRL, ctl(1, 0, 1, m));
      settle();
      rdRg(bsync_pkg::ADDR_STAT, d);
      chk(32'(d[11:8]), 32'(8 + m));
      chk(32'(syncedOut), 32'(m == 0 || m == 2));
    end
    wrRg(bsync_pkg::ADDR_CTRL, ctl(1, 1, 0, 0));
    settle();
    rdRg(bsync_pkg::ADDR_STAT, d);
    chk(32'(d[11:8]), 32'h0);
    c0 = meas.closeCnt;
    meas.setCh(6, 12000, 5000, 0);
    blockIn <= 1'h1;
    wrRg(bsync_pkg::ADDR_CTRL, ctl(1, 1, 1, 0));
    settle();
    meas.setCh(6, 10000, 5000, 0);
    settle();
    chk(32'(syncedOut), 32'h0);
    chk(32'(meas.closeCnt - c0), 32'h0);
    rdRg(bsync_pkg::ADDR_STAT, d);
    chk(32'(d[11:8]), 32'h9);
    rdRg(bsync_pkg::ADDR_IRQST, d);
    chk(32'(d[4]), 32'h1);
    @(posedge clock);
    blockIn <= 1'h0;
  endtask

  initial begin
    srst = 1'h1;
    regWr = 1'h0;
    regRd = 1'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    blockIn = 1'h0;
    repeat (2) @(posedge clock);
    srst <= 1'h0;
    tResetVals();
    tSingle();
    tLimits();
    tDual();
    tVcond();
    tClose();
    tModes();
    wrapUp();
  end
endmodule
